// ---- inc/ras_pkg.sv ----
package ras_pkg;
  localparam int ADDR_W = 15;
  localparam int DEPTH = 16;
  localparam logic [4:0] PTR_EMPTY = 5'h1F;
  localparam logic [4:0] PTR_WRAP = 5'h10;
  localparam logic [4:0] PTR_TOP_FULL = 5'h0F;
  localparam logic [4:0] PTR_RESET = 5'h1F;

  typedef struct packed {
    logic push;
    logic pop;
    logic [ADDR_W-1:0] ret_addr;
  } ras_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] pc_load;
    logic pc_load_valid;
  } ras_rsp_t;
endpackage

// ---- verilog/ras_fault.sv ----
`timescale 1ns/1ps
// flags a push past the sixteenth level or a pop past the first
module ras_fault (
  input wire logic [4:0] stack_level_pointer,
  input wire logic push,
  input wire logic pop,
  output logic push_over,
  output logic pop_under
);
  assign push_over = push && (stack_level_pointer == ras_pkg::PTR_TOP_FULL);
  assign pop_under = pop && (stack_level_pointer == ras_pkg::PTR_EMPTY);
endmodule // ras_fault

// ---- verilog/return_address_stack.sv ----
`timescale 1ns/1ps
// Summary of operation
// - push on every call and interrupt entry
// - return loads pc from top, then pops
// - push on full stack moves pointer to 0x10
// - pointer 0x10 aliases entry 0x00, overwrites
// - fault reset enabled: reset, keep entry 0x00
// - emptying return sets pointer to 0x1F
// - fault reset on over/underflow sets status flag

module return_address_stack #(
  parameter int ADDR_W = ras_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire ras_pkg::ras_req_t req,
  input wire logic stack_fault_reset_enable,
  input wire logic clear_overflow_flag,
  input wire logic clear_underflow_flag,
  output ras_pkg::ras_rsp_t rsp,
  output logic [4:0] stack_level_pointer,
  output logic [ADDR_W-1:0] top_entry,
  output logic stack_fault_reset,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag
);

  // one word per level; entries are not cleared by reset
  logic [ADDR_W-1:0] mem [ras_pkg::DEPTH];

  // decoded request
  logic push_req;
  logic pop_req;
  logic [ADDR_W-1:0] push_data;

  // fault detection
  logic push_over;
  logic pop_under;
  logic fault_push;
  logic fault_pop;
  logic fault_any;

  // pointer and storage access
  logic [4:0] next_ptr;
  logic [3:0] write_slot;
  logic [3:0] read_slot;
  logic write_en;
  logic [ADDR_W-1:0] read_word;

  // sticky status flags
  logic next_overflow_flag;
  logic next_underflow_flag;

  // storage slot of a pointer value; 0x10 folds onto entry 0x00
  function automatic logic [3:0] slot(input logic [4:0] p);
    return p[3:0];
  endfunction

  function automatic logic is_empty(input logic [4:0] p);
    return p == ras_pkg::PTR_EMPTY;
  endfunction

  function automatic logic is_wrapped(input logic [4:0] p);
    return p == ras_pkg::PTR_WRAP;
  endfunction

  function automatic logic is_bottom(input logic [4:0] p);
    return p == 5'h00;
  endfunction

  // pointer after one push: empty goes to 0x00, the alias 0x10 moves on to 0x01
  function automatic logic [4:0] ptr_after_push(input logic [4:0] p);
    logic [4:0] n;
    n = 5'(p + 5'h01);
    if (is_empty(p)) begin
      n = 5'h00;
    end
    if (is_wrapped(p)) begin
      n = 5'h01;
    end
    return n;
  endfunction

  // pointer after one pop: leaving entry 0x00 or its alias empties the stack
  function automatic logic [4:0] ptr_after_pop(input logic [4:0] p);
    logic [4:0] n;
    n = 5'(p - 5'h01);
    if (is_bottom(p)) begin
      n = ras_pkg::PTR_EMPTY;
    end
    if (is_wrapped(p)) begin
      n = ras_pkg::PTR_EMPTY;
    end
    return n;
  endfunction

  // push wins when the sequencer raises both in one cycle
  assign push_req = req.push;
  assign pop_req = req.pop && !req.push;
  assign push_data = req.ret_addr;

  // level decode for over- and underflow
  ras_fault u_fault (
    .stack_level_pointer(stack_level_pointer),
    .push(push_req),
    .pop(pop_req),
    .push_over(push_over),
    .pop_under(pop_under)
  );

  // with the fault reset option off, over- and underflow simply wrap
  assign fault_push = push_over && stack_fault_reset_enable;
  assign fault_pop = pop_under && stack_fault_reset_enable;
  assign fault_any = fault_push || fault_pop;

  always_comb begin
    next_ptr = stack_level_pointer;
    case ({push_req, pop_req})
      2'b10: begin
        next_ptr = ptr_after_push(stack_level_pointer);
      end
      2'b01: begin
        next_ptr = ptr_after_pop(stack_level_pointer);
      end
      default: begin
        next_ptr = stack_level_pointer;
      end
    endcase
  end

  // an overflowing push under fault reset leaves entry 0x00 untouched
  always_comb begin
    write_en = push_req && !fault_push;
    write_slot = slot(next_ptr);
  end

  // top of stack as seen through the pointer
  always_comb begin
    read_slot = slot(stack_level_pointer);
    read_word = mem[read_slot];
  end

  // a fault puts the pointer back to its reset value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_level_pointer <= ras_pkg::PTR_RESET;
    end else if (fault_push) begin
      stack_level_pointer <= ras_pkg::PTR_RESET;
    end else if (fault_pop) begin
      stack_level_pointer <= ras_pkg::PTR_RESET;
    end else begin
      stack_level_pointer <= next_ptr;
    end
  end

  // return address storage
  always_ff @(posedge core_clk) begin
    if (write_en) begin
      mem[write_slot] <= push_data;
    end
  end

  // pc_load is only refreshed by a return so it holds the last popped address
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.pc_load_valid <= pop_req && !fault_pop;
      if (pop_req) begin
        rsp.pc_load <= read_word;
      end
    end
  end

  // one-cycle request for a device reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_fault_reset <= 1'b0;
    end else begin
      stack_fault_reset <= fault_any;
    end
  end

  // a fault in the same cycle as a clear wins over the clear
  always_comb begin
    next_overflow_flag = stack_overflow_flag;
    next_underflow_flag = stack_underflow_flag;
    if (clear_overflow_flag) begin
      next_overflow_flag = 1'b0;
    end
    if (clear_underflow_flag) begin
      next_underflow_flag = 1'b0;
    end
    if (fault_push) begin
      next_overflow_flag = 1'b1;
    end
    if (fault_pop) begin
      next_underflow_flag = 1'b1;
    end
  end

  // overflow status
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_overflow_flag <= 1'b0;
    end else begin
      stack_overflow_flag <= next_overflow_flag;
    end
  end

  // underflow status
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_underflow_flag <= 1'b0;
    end else begin
      stack_underflow_flag <= next_underflow_flag;
    end
  end

  // combinational view of the top entry; meaningless while empty
  assign top_entry = read_word;
endmodule // return_address_stack

// ---- test/ras_seq.sv ----
`timescale 1ns/1ps
// core sequencer stand-in: one request per cycle, push wins
module ras_seq (
  input wire logic c,
  input wire logic r,
  input wire logic [14:0] a,
  output ras_pkg::ras_req_t q
);
  assign q = '{c, r & ~c, a};
endmodule // ras_seq

// ---- test/ras_asserts.sv ----
`timescale 1ns/1ps
module ras_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire ras_pkg::ras_req_t req,
  input wire logic stack_fault_reset_enable,
  input wire ras_pkg::ras_rsp_t rsp,
  input wire logic [4:0] stack_level_pointer,
  input wire logic [14:0] top_entry,
  input wire logic stack_fault_reset,
  input wire logic stack_overflow_flag,
  input wire logic stack_underflow_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic [4:0] p = stack_level_pointer;
  wire logic u = req.push;
  wire logic o = req.pop & ~req.push;
  wire logic e = stack_fault_reset_enable;
  wire logic f = stack_fault_reset;
  a_push_level: assert property (u && (p < 5'h0F || p == 5'h1F) |=> p == $past(p) + 5'h01) else $error("push");
  a_ret_load: assert property (o && p < 5'h10 |=> rsp.pc_load_valid && rsp.pc_load == $past(top_entry))
    else $error("ret");
  a_wrap_level: assert property (u && p == 5'h0F && !e |=> p == 5'h10) else $error("wrap");
  a_wrap_alias: assert property (u && p == 5'h0F && !e |=> top_entry == $past(req.ret_addr)) else $error("alias");
  a_ovf_reset: assert property (u && p == 5'h0F && e |=> f && stack_overflow_flag && p == 5'h1F) else $error("ovf");
  a_empty_level: assert property (o && p == 5'h00 |=> p == 5'h1F) else $error("empty");
  a_unf_reset: assert property (o && p == 5'h1F && e |=> f && stack_underflow_flag && !rsp.pc_load_valid)
    else $error("unf");
  c_wrap: cover property (p == 5'h10);
  c_fault: cover property (f);
  c_ret: cover property (rsp.pc_load_valid);
endmodule // ras_asserts
bind return_address_stack ras_asserts chk (.*);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, rst = 1, c = 0, r = 0, e = 0, co = 0, cu = 0, fr, of, uf;
  logic [14:0] a = 0, t;
  logic [4:0] p;
  int failures = 0, checks_done = 0, cyc = 0;
  ras_pkg::ras_req_t q;
  ras_pkg::ras_rsp_t s;
  ras_seq bfm (.c(c), .r(r), .a(a), .q(q));
  return_address_stack dut (.core_clk(core_clk), .rst(rst), .req(q), .stack_fault_reset_enable(e),
    .clear_overflow_flag(co), .clear_underflow_flag(cu), .rsp(s), .stack_level_pointer(p), .top_entry(t),
    .stack_fault_reset(fr), .stack_overflow_flag(of), .stack_underflow_flag(uf));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 400) begin failures++; wrap_up; end
  task chk(input logic [23:0] v, x);
    checks_done++;
    if (v !== x) begin failures++; $display("wrong value at %0t: got %h want %h", $time, v, x); end
  endtask
  task go(input logic pu, po, input logic [14:0] ad);
    @(posedge core_clk) {c, r, a} <= {pu, po, ad};
    @(posedge core_clk) {c, r} <= 2'b00;
    #1;
  endtask
  task s_ret;
    go(1, 0, 15'h1234);
    chk(p, 5'h00);
    go(0, 1, 15'h0000);
    chk({s.pc_load_valid, s.pc_load, p}, {1'b1, 15'h1234, 5'h1F});
  endtask
  // seventeen pushes: the last lands in entry 0
  task s_wrap;
    for (int i = 0; i < 17; i++) go(1, 0, 15'(i));
    chk({t, p}, {15'h0010, 5'h10});
    go(0, 1, 15'h0000);
    chk({s.pc_load, p}, {15'h0010, 5'h1F});
  endtask
  task s_ovf;
    @(posedge core_clk) e <= 1'b1;
    for (int i = 0; i < 17; i++) go(1, 0, 15'h7F00 | 15'(i));
    chk({fr, of, p}, {2'b11, 5'h1F});
    go(0, 1, 15'h0000);
    chk({fr, uf, s.pc_load_valid, p}, {3'b110, 5'h1F});
    @(posedge core_clk) {e, co} <= 2'b01;
    @(posedge core_clk) co <= 1'b0;
    #1;
    chk({of, uf}, 2'b01);
    go(0, 1, 15'h0000);
    chk({s.pc_load_valid, s.pc_load, p}, {1'b1, 15'h7F0F, 5'h1E});
    for (int i = 0; i < 14; i++) go(0, 1, 15'h0000);
    chk({t, p}, {15'h7F00, 5'h10});
  endtask
  task s_reset;
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk({of, uf, fr, s.pc_load_valid, p}, {4'b0000, 5'h1F});
    go(1, 0, 15'h0ABC);
    chk({t, p}, {15'h0ABC, 5'h00});
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    s_ret;
    s_wrap;
    s_ovf;
    s_reset;
    wrap_up;
  end
endmodule // testbench
